// [rtl/ppm_pin_map.sv]
// Programmable pad mapper: function, drive and pull of 22 pads.
// Assumes pad buffers outside apply drive, enable and pulls,
// and core logic supplies the function signals and map writes.
`include "ppm_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module ppm_pin_map (
  input  wire logic                  clk_in,
  input  wire logic                  rst_b_in,
  input  wire logic [21:0]           pad_in,
  input  wire logic                  uart_txd_in,
  input  wire logic                  uart_rts_in,
  input  wire logic                  spi_do_in,
  input  wire logic                  spi_flow_in,
  input  wire logic                  wake_in,
  input  wire logic                  core_clk_req_in,
  input  wire logic                  spi_cfg_wr_in,
  input  wire logic [4:0]            spi_flow_pad_in,
  input  wire logic                  map_wr_in,
  input  wire logic [4:0]            map_pad_in,
  input  wire ppm_pkg::ppm_func_e    map_func_in,
  input  wire ppm_pkg::ppm_pull_e    map_pull_in,
  output logic [21:0]                pad_drive_out,
  output logic [21:0]                pad_oe_out,
  output logic [21:0]                pad_pull_up_out,
  output logic [21:0]                pad_pull_down_out,
  output logic [21:0]                pad_level_out,
  output logic [1:0]                 host_if_out,
  output logic                       map_done_out,
  output logic                       map_refused_out
);

  // ========================================================
  // Functions
  // Function shown on a pad once reset and setup are over
  function automatic ppm_pkg::ppm_func_e dflt_func(input int i);
    ppm_pkg::ppm_func_e f;
    f = ppm_pkg::pf_input;
    if (i == `PPM_PAD_TXD || i == `PPM_PAD_RTS) begin
      f = ppm_pkg::pf_high;
    end else if (i == `PPM_PAD_SDO) begin
      f = ppm_pkg::pf_spi_do;
    end else if (i == `PPM_PAD_WAKE || i == `PPM_PAD_CRQN) begin
      f = ppm_pkg::pf_low;
    end else if (i == `PPM_PAD_CRQO) begin
      f = ppm_pkg::pf_high;
    end
    return f;
  endfunction : dflt_func

  // Pull taken from a pair of masks
  function automatic ppm_pkg::ppm_pull_e mask_pull(
    input logic [21:0] pu,
    input logic [21:0] pd,
    input int          i
  );
    ppm_pkg::ppm_pull_e p;
    p = ppm_pkg::pull_none;
    if (pu[i]) begin
      p = ppm_pkg::pull_up;
    end else if (pd[i]) begin
      p = ppm_pkg::pull_down;
    end
    return p;
  endfunction : mask_pull

  // Pull shown once setup is over; a driven pad other than SDO carries no pull,
  // so its driver never fights a resistor toward the other rail
  function automatic ppm_pkg::ppm_pull_e dflt_pull(input int i);
    ppm_pkg::ppm_func_e f;
    ppm_pkg::ppm_pull_e p;
    f = dflt_func(i);
    p = mask_pull(`PPM_DEF_PU, `PPM_RST_PD, i);
    if (f != ppm_pkg::pf_input && f != ppm_pkg::pf_spi_do) begin
      p = ppm_pkg::pull_none;
    end
    return p;
  endfunction : dflt_pull

  // Drive pair {enable, level} for a pad function
  function automatic logic [1:0] pad_drive(
    input ppm_pkg::ppm_func_e f,
    input logic               spi_on,
    input logic               sel_lvl
  );
    logic [1:0] d;
    d = 2'h0;
    unique case (f)
      ppm_pkg::pf_input:     d = 2'h0;
      ppm_pkg::pf_low:       d = 2'h2;
      ppm_pkg::pf_high:      d = 2'h3;
      ppm_pkg::pf_uart_tx:   d = {1'b1, uart_txd_in};
      ppm_pkg::pf_uart_rts:  d = {1'b1, uart_rts_in};
      // Only drive while adopted and selected; shared bus otherwise
      ppm_pkg::pf_spi_do:    d = {spi_on & ~sel_lvl, spi_do_in};
      ppm_pkg::pf_spi_flow:  d = {1'b1, spi_flow_in};
      ppm_pkg::pf_wake:      d = {1'b1, wake_in};
      ppm_pkg::pf_clk_req:   d = {1'b1, core_clk_req_in};
      ppm_pkg::pf_clk_req_n: d = {1'b1, ~core_clk_req_in};
      default:               d = 2'h0;
    endcase
    return d;
  endfunction : pad_drive

  // ========================================================
  // State
  ppm_pkg::ppm_phase_e phase_reg;
  ppm_pkg::ppm_phase_e phase_next;
  ppm_pkg::ppm_func_e  func_reg [`PPM_NPAD];
  ppm_pkg::ppm_pull_e  pull_reg [`PPM_NPAD];
  logic [21:0]         sync1_reg;
  logic [21:0]         sync2_reg;
  logic [21:0]         sync3_reg;
  logic [21:0]         filt_reg;
  logic [4:0]          flow_pad_reg;
  logic                flow_set_reg;
  logic                uart_seen;
  logic                spi_seen;
  logic                map_ok;
  logic                cfg_ok;

  // ========================================================
  // Pad input synchronisers
  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_reg <= `PPM_RST_PU;
      sync2_reg <= `PPM_RST_PU;
      sync3_reg <= `PPM_RST_PU;
    end else begin
      sync1_reg <= pad_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Filtered level, held where the two late stages disagree
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      filt_reg <= `PPM_RST_PU;
    end else begin
      filt_reg <= (sync2_reg & sync3_reg) |
                  (filt_reg & (sync2_reg ^ sync3_reg));
    end
  end

  // ========================================================
  // Host link detection and request checks
  // Start bit on receive or select pulled low marks host data;
  // UART wins a tie since its start bit is the older evidence
  always_comb begin
    uart_seen = (phase_reg == ppm_pkg::st_default) &&
                !filt_reg[`PPM_PAD_RXD];
    spi_seen  = (phase_reg == ppm_pkg::st_default) &&
                !filt_reg[`PPM_PAD_SEL] && !uart_seen;
    map_ok    = map_wr_in && (map_pad_in < `PPM_NPAD_LIM) &&
                (phase_reg == ppm_pkg::st_uart ||
                 phase_reg == ppm_pkg::st_spi);
    cfg_ok    = spi_cfg_wr_in && (spi_flow_pad_in < `PPM_NPAD_LIM) &&
                (phase_reg == ppm_pkg::st_spi);
  end

  // Next phase; adoption is final until the next reset
  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      ppm_pkg::st_init:    phase_next = ppm_pkg::st_default;
      ppm_pkg::st_default: begin
        if (uart_seen) begin
          phase_next = ppm_pkg::st_uart;
        end else if (spi_seen) begin
          phase_next = ppm_pkg::st_spi;
        end
      end
      ppm_pkg::st_uart:    phase_next = ppm_pkg::st_uart;
      ppm_pkg::st_spi:     phase_next = ppm_pkg::st_spi;
    endcase
  end

  // Phase register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase_reg <= ppm_pkg::st_init;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ========================================================
  // Pad configuration table
  // Steps in order: defaults, auto remap, SPI config, map write;
  // in one cycle only the earliest step that applies takes effect
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < `PPM_NPAD; i++) begin
        func_reg[i] <= ppm_pkg::pf_input;
        pull_reg[i] <= mask_pull(`PPM_RST_PU, `PPM_RST_PD, i);
      end
    end else if (phase_reg == ppm_pkg::st_init) begin
      for (int i = 0; i < `PPM_NPAD; i++) begin
        func_reg[i] <= dflt_func(i);
        pull_reg[i] <= dflt_pull(i);
      end
    end else if (uart_seen) begin
      // Auto remap for the adopted link
      func_reg[`PPM_PAD_TXD] <= ppm_pkg::pf_uart_tx;
      func_reg[`PPM_PAD_RTS] <= ppm_pkg::pf_uart_rts;
      func_reg[`PPM_PAD_SDO] <= ppm_pkg::pf_input;
    end else if (spi_seen) begin
      func_reg[`PPM_PAD_TXD]  <= ppm_pkg::pf_input;
      pull_reg[`PPM_PAD_TXD]  <= ppm_pkg::pull_up;
      func_reg[`PPM_PAD_RTS]  <= ppm_pkg::pf_input;
      pull_reg[`PPM_PAD_RTS]  <= ppm_pkg::pull_up;
      func_reg[`PPM_PAD_WAKE] <= ppm_pkg::pf_wake;
    end else if (cfg_ok) begin
      // Previous flow pad falls back to a quiet pulled-down input
      if (flow_set_reg) begin
        func_reg[flow_pad_reg] <= ppm_pkg::pf_input;
        pull_reg[flow_pad_reg] <= ppm_pkg::pull_down;
      end
      func_reg[spi_flow_pad_in] <= ppm_pkg::pf_spi_flow;
    end else if (map_ok) begin
      // Host remap; pad index already range-checked
      func_reg[map_pad_in] <= map_func_in;
      pull_reg[map_pad_in] <= map_pull_in;
    end
  end

  // Flow pad bookkeeping, so a moved flow pad releases the old one
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flow_pad_reg <= 5'h00;
      flow_set_reg <= 1'b0;
    end else if (cfg_ok) begin
      // Config wins over a map write, so it always lands in the table
      flow_pad_reg <= spi_flow_pad_in;
      flow_set_reg <= 1'b1;
    end else if (map_ok && flow_set_reg && map_pad_in == flow_pad_reg) begin
      flow_set_reg <= 1'b0;
    end
  end

  // ========================================================
  // Pad outputs
  // Registered so pads never glitch on a table rewrite
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pad_drive_out     <= 22'h000000;
      pad_oe_out        <= 22'h000000;
      pad_pull_up_out   <= `PPM_RST_PU;
      pad_pull_down_out <= `PPM_RST_PD;
    end else begin
      for (int i = 0; i < `PPM_NPAD; i++) begin
        {pad_oe_out[i], pad_drive_out[i]} <=
          pad_drive(func_reg[i], phase_reg == ppm_pkg::st_spi,
                    filt_reg[`PPM_PAD_SEL]);
        pad_pull_up_out[i]   <= pull_reg[i] == ppm_pkg::pull_up;
        pad_pull_down_out[i] <= pull_reg[i] == ppm_pkg::pull_down;
      end
    end
  end

  // ========================================================
  // Core-facing status
  // Filtered levels let the core read input functions on any pad
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pad_level_out   <= `PPM_RST_PU;
      host_if_out     <= `PPM_IF_NONE;
      map_done_out    <= 1'b0;
      map_refused_out <= 1'b0;
    end else begin
      pad_level_out <= filt_reg;
      unique case (phase_reg)
        ppm_pkg::st_uart: host_if_out <= `PPM_IF_UART;
        ppm_pkg::st_spi:  host_if_out <= `PPM_IF_SPI;
        ppm_pkg::st_init, ppm_pkg::st_default: host_if_out <= `PPM_IF_NONE;
      endcase
      // A map write beside a config write loses to it and is refused
      map_done_out    <= (map_ok && !cfg_ok) || cfg_ok;
      map_refused_out <= (map_wr_in && !(map_ok && !cfg_ok)) ||
                         (spi_cfg_wr_in && !cfg_ok);
    end
  end

endmodule : ppm_pin_map

`default_nettype wire

// [rtl/ppm_consts.svh]
// Constants for the programmable pad mapper.
// Assumes inclusion by the pad mapper module, its checker and the bench.
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH

// ==========================================================
// Pad count and index layout
`define PPM_NPAD      22
`define PPM_NPAD_LIM  5'h16
`define PPM_PAD_RXD   0
`define PPM_PAD_TXD   1
`define PPM_PAD_CTS   2
`define PPM_PAD_RTS   3
`define PPM_PAD_SDO   6
`define PPM_PAD_SEL   7
`define PPM_PAD_RCLK  12
`define PPM_PAD_RDAT  13
`define PPM_PAD_WAKE  18
`define PPM_PAD_CRQO  20
`define PPM_PAD_CRQN  21

// ==========================================================
// Pull masks, one bit per pad
`define PPM_RST_PU    22'h20308F
`define PPM_RST_PD    22'h1FCF70
`define PPM_DEF_PU    22'h003085

// ==========================================================
// Adopted host link codes
`define PPM_IF_NONE   2'h0
`define PPM_IF_UART   2'h1
`define PPM_IF_SPI    2'h2

`endif

// [rtl/ppm_pkg.sv]
// Types shared by the programmable pad mapper and its bench.
// Assumes ppm_consts.svh sits on the include path.
package ppm_pkg;

  // ========================================================
  // Pad functions and pulls
  typedef enum logic [3:0] {
    pf_input, pf_low, pf_high, pf_uart_tx, pf_uart_rts,
    pf_spi_do, pf_spi_flow, pf_wake, pf_clk_req, pf_clk_req_n
  } ppm_func_e;

  typedef enum logic [1:0] {
    pull_none, pull_down, pull_up
  } ppm_pull_e;

  // ========================================================
  // Mapping phase
  typedef enum {
    st_init, st_default, st_uart, st_spi
  } ppm_phase_e;

endpackage : ppm_pkg

// [dv/ppm_pin_map_asserts.sv]
// Port checker for the pad mapper, bound onto its top module.
// Assumes one clock domain and the constants header on the include path.
`include "ppm_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module ppm_pin_map_asserts (
  input wire logic               clk_in,
  input wire logic               rst_b_in,
  input wire logic               spi_cfg_wr_in,
  input wire logic               map_wr_in,
  input wire logic [4:0]         map_pad_in,
  input wire ppm_pkg::ppm_func_e map_func_in,
  input wire ppm_pkg::ppm_pull_e map_pull_in,
  input wire logic [21:0]        pad_drive_out,
  input wire logic [21:0]        pad_oe_out,
  input wire logic [21:0]        pad_pull_up_out,
  input wire logic [21:0]        pad_pull_down_out,
  input wire logic [1:0]         host_if_out,
  input wire logic               map_done_out,
  input wire logic               map_refused_out
);
  // ==========================================================
  // Helpers
  logic [2:0] age_reg;
  logic       ok_wr;
  // Edges since reset release, saturating so it never wraps
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) age_reg <= 3'h0;
    else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
  end
  // A remap the block has no reason to refuse
  assign ok_wr = map_wr_in && host_if_out != 2'h0 && map_pad_in < 5'h16 && !spi_cfg_wr_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ==========================================================
  // Assertions
  chk_reset_state: assert property ($rose(rst_b_in) |-> pad_oe_out == 22'h0 &&
    pad_pull_up_out == `PPM_RST_PU && pad_pull_down_out == `PPM_RST_PD) else $error("reset pad state wrong");
  chk_default_up: assert property (age_reg == 3'h2 |-> pad_pull_up_out == `PPM_DEF_PU &&
    pad_oe_out == 22'h34000A) else $error("default pull-up or enable wrong");
  chk_default_hold: assert property (host_if_out == 2'h0 && age_reg > 3'h2 |-> $stable(pad_oe_out) &&
    $stable(pad_pull_up_out) && $stable(pad_pull_down_out)) else $error("default state moved");
  chk_early_refuse: assert property (map_wr_in && age_reg < 3'h4 |=> map_refused_out && !map_done_out)
    else $error("early remap not refused");
  chk_map_accept: assert property (ok_wr |=> map_done_out && !map_refused_out)
    else $error("remap not accepted");
  chk_drive_apply: assert property (ok_wr && map_func_in == ppm_pkg::pf_high |-> ##2
    pad_oe_out[$past(map_pad_in, 2)] && pad_drive_out[$past(map_pad_in, 2)]) else $error("remap drive wrong");
  chk_pull_apply: assert property (ok_wr && map_func_in == ppm_pkg::pf_input |-> ##2
    !pad_oe_out[$past(map_pad_in, 2)] && pad_pull_up_out[$past(map_pad_in, 2)] ==
    ($past(map_pull_in, 2) == ppm_pkg::pull_up)) else $error("remap pull wrong");
  chk_link_hold: assert property (host_if_out != 2'h0 |=> $stable(host_if_out))
    else $error("host link changed");
  cov_uart: cover property (host_if_out == 2'h1);
  cov_spi: cover property (host_if_out == 2'h2);
  cov_refuse: cover property (map_refused_out);
endmodule : ppm_pin_map_asserts
bind ppm_pin_map ppm_pin_map_asserts ppm_pin_map_asserts_i (.clk_in, .rst_b_in, .spi_cfg_wr_in, .map_wr_in,
  .map_pad_in, .map_func_in, .map_pull_in, .pad_drive_out, .pad_oe_out, .pad_pull_up_out, .pad_pull_down_out,
  .host_if_out, .map_done_out, .map_refused_out);
`default_nettype wire

// [dv/ppm_host_model.sv]
// Host and board model: resolves pad levels, pulls the link low to talk.
// Assumes talk_in changes just after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module ppm_host_model (
  input  wire logic        clk_in,
  input  wire logic [1:0]  talk_in,
  input  wire logic [21:0] drive_in,
  input  wire logic [21:0] oe_in,
  input  wire logic [21:0] pu_in,
  input  wire logic [21:0] pd_in,
  output logic      [21:0] pad_out
);
  // ==========================================================
  // Pad resolution
  logic flip_reg = 1'b0;
  // Floating pads wander, so a stale level never looks real
  always @(posedge clk_in) begin
    flip_reg <= ~flip_reg;
  end
  // Driver first, then pull; host holds receive or select low while talking
  always_comb begin
    for (int i = 0; i < 22; i++) begin
      pad_out[i] = oe_in[i] ? drive_in[i] : pu_in[i] ? 1'b1 : pd_in[i] ? 1'b0 : flip_reg;
    end
    if (talk_in == 2'h1) pad_out[0] = 1'b0;
    if (talk_in == 2'h2) pad_out[7] = 1'b0;
  end
endmodule : ppm_host_model
`default_nettype wire

// [dv/tb.sv]
// Bench for the pad mapper: reset, defaults, link adoption and remaps.
// Assumes the host model and the bound checker are compiled with it.
`include "ppm_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct {logic ok; logic [4:0] pad; ppm_pkg::ppm_func_e fn; ppm_pkg::ppm_pull_e pl;} ppm_note_s;
  logic               clk_in = 1'b0;
  logic               rst_b_in, map_wr_in, spi_cfg_wr_in, wake_in, map_done_out, map_refused_out;
  logic               live = 1'b0;
  logic [1:0]         talk, host_if_out;
  logic [4:0]         map_pad_in, flow_pad;
  logic [21:0]        pad_in, pad_drive_out, pad_oe_out, pad_pull_up_out, pad_pull_down_out, pad_level_out;
  ppm_pkg::ppm_func_e map_func_in;
  ppm_pkg::ppm_pull_e map_pull_in;
  ppm_note_s          note_q[$], cur;
  int                 fail_count = 0, total_checks = 0, seed = 32'h773e, r;
  // ==========================================================
  // Design and host
  ppm_pin_map ppm_pin_map_i (.clk_in, .rst_b_in, .pad_in, .uart_txd_in(1'b0), .uart_rts_in(1'b1),
    .spi_do_in(1'b0), .spi_flow_in(1'b1), .wake_in, .core_clk_req_in(1'b1), .spi_cfg_wr_in,
    .spi_flow_pad_in(flow_pad), .map_wr_in, .map_pad_in, .map_func_in, .map_pull_in, .pad_drive_out,
    .pad_oe_out, .pad_pull_up_out, .pad_pull_down_out, .pad_level_out, .host_if_out, .map_done_out,
    .map_refused_out);
  ppm_host_model ppm_host_model_i (.clk_in, .talk_in(talk), .drive_in(pad_drive_out), .oe_in(pad_oe_out),
    .pu_in(pad_pull_up_out), .pd_in(pad_pull_down_out), .pad_out(pad_in));
  // 4 ns clock
  always #2 clk_in = ~clk_in;
  // ==========================================================
  // Tasks
  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic do_reset;
    rst_b_in = 1'b0;
    talk = 2'h0;
    repeat (6) @(posedge clk_in);
    #1;
    check(pad_oe_out, 22'h0);
    check(pad_pull_up_out, `PPM_RST_PU);
    check(pad_pull_down_out, `PPM_RST_PD);
    rst_b_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    check(pad_pull_up_out, `PPM_DEF_PU);
    check(pad_pull_down_out, 22'h0BCF70);
    check(pad_oe_out, 22'h34000A);
    check(pad_drive_out & 22'h10000A, 22'h10000A);
  endtask : do_reset
  // Leaves the strobe up so back-to-back calls never retoggle it
  task automatic map_write(input logic [4:0] pad, input ppm_pkg::ppm_func_e f, input ppm_pkg::ppm_pull_e p,
                           input logic ok);
    map_wr_in = 1'b1;
    map_pad_in = pad;
    map_func_in = f;
    map_pull_in = p;
    note_q.push_back(ppm_note_s'{ok, pad, f, p});
    @(posedge clk_in);
    #1;
  endtask : map_write
  task automatic wait_link(input logic [1:0] want);
    int n = 0;
    while (host_if_out !== want && n < 50) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check(host_if_out, want);
    if (host_if_out !== want) give_verdict();
  endtask : wait_link
  // Each done or refused pulse retires the oldest note; pads settle one edge later
  always @(negedge clk_in) begin
    if (live && cur.fn == ppm_pkg::pf_input)
      check({pad_oe_out[cur.pad], pad_pull_up_out[cur.pad]}, {1'b0, cur.pl == ppm_pkg::pull_up});
    else if (live)
      check({pad_oe_out[cur.pad], pad_drive_out[cur.pad]}, {1'b1, cur.fn == ppm_pkg::pf_high});
    live = 1'b0;
    if (map_done_out || map_refused_out) begin
      cur = note_q.pop_front();
      check({map_done_out, map_refused_out}, {cur.ok, !cur.ok});
      live = cur.ok;
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    {map_wr_in, spi_cfg_wr_in, wake_in, map_pad_in, flow_pad} = '0;
    map_func_in = ppm_pkg::pf_input;
    map_pull_in = ppm_pkg::pull_none;
    do_reset();
    map_write(5'h9, ppm_pkg::pf_high, ppm_pkg::pull_none, 1'b0);
    map_wr_in = 1'b0;
    $display("test defaults done");
    talk = 2'h1;
    wait_link(2'h1);
    // Transmit pad now follows the core's low transmit level, not the default high
    check({pad_oe_out[1], pad_drive_out[1]}, 2'h2);
    talk = 2'h2;
    repeat (8) @(posedge clk_in);
    #1;
    check(host_if_out, 2'h1);
    talk = 2'h0;
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      wake_in = r[7];
      map_write(5'(8 + r[1:0] + (r[2] ? 6 : 0)), ppm_pkg::ppm_func_e'(4'(r[4:3] % 3)),
                ppm_pkg::ppm_pull_e'(2'(r[6:5] % 3)), 1'b1);
    end
    map_write(5'h16, ppm_pkg::pf_high, ppm_pkg::pull_none, 1'b0);
    map_wr_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    // Clock request pads keep their driven levels through the remaps
    check(pad_level_out[21:20], 2'h1);
    $display("test uart remap done");
    do_reset();
    talk = 2'h2;
    wait_link(2'h2);
    repeat (2) @(posedge clk_in);
    #1;
    check(pad_pull_up_out, 22'h00308F);
    check(pad_oe_out[6], 1'b1);
    spi_cfg_wr_in = 1'b1;
    flow_pad = 5'hA;
    note_q.push_back(ppm_note_s'{1'b1, 5'hA, ppm_pkg::pf_high, ppm_pkg::pull_none});
    @(posedge clk_in);
    #1;
    spi_cfg_wr_in = 1'b0;
    map_write(5'hB, ppm_pkg::pf_input, ppm_pkg::pull_up, 1'b1);
    map_wr_in = 1'b0;
    // Move the flow pad; the old one must fall back to a pulled-down input
    spi_cfg_wr_in = 1'b1;
    flow_pad = 5'h9;
    note_q.push_back(ppm_note_s'{1'b1, 5'h9, ppm_pkg::pf_high, ppm_pkg::pull_none});
    @(posedge clk_in);
    #1;
    spi_cfg_wr_in = 1'b0;
    talk = 2'h0;
    repeat (8) @(posedge clk_in);
    #1;
    check(pad_oe_out[6], 1'b0);
    check({pad_oe_out[10], pad_pull_down_out[10]}, 2'h1);
    $display("test spi done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
